/* design/gtc_consts.vh */
// Constants for the gated sixteen-bit timer/counter
`ifndef GTC_CONSTS_VH
`define GTC_CONSTS_VH
`define GTC_ADDR_INTCTL 8'h0b
`define GTC_ADDR_PFLAGS 8'h0c
`define GTC_ADDR_CNTLO 8'h0e
`define GTC_ADDR_CNTHI 8'h0f
`define GTC_ADDR_TCTL 8'h10
`define GTC_ADDR_PENABLE 8'h8c
`define GTC_TCTL_RESET 7'h00
`define GTC_INTCTL_RESET 2'h0
`define GTC_BIT_ON 0
`define GTC_BIT_SRC 1
`define GTC_BIT_SYNC_N 2
`define GTC_BIT_OSC 3
`define GTC_BIT_PS_LO 4
`define GTC_BIT_PS_HI 5
`define GTC_BIT_GATE 6
`define GTC_BIT_PERIPHERAL_IRQ_ENABLE 6
`define GTC_BIT_GIE 7
`define GTC_BIT_OVF 0
`define GTC_INSTR_DIV 4
`endif

/* design/gtc_timer.v */
// Gated sixteen-bit timer/counter with register port
`timescale 1ns/1ps
`include "gtc_consts.vh"
module gtc_timer #(
  parameter INSTR_DIV = `GTC_INSTR_DIV
) (
  input wire clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire ext_count_clock,
  input wire count_gate_n,
  input wire sleep_mode,
  input wire [1:0] pin45_dir_in,
  input wire [1:0] pin45_level_in,
  output reg [1:0] pin45_dir_out,
  output reg [1:0] pin45_read_out,
  output reg low_power_crystal_osc,
  output wire irq_out,
  output wire wake_out
);

  // Reset release
  // Asserts at once, releases on the clock so no flop leaves reset unevenly
  reg rst_s1_ff;
  reg rst_s2_ff;
  wire rst_n;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  assign rst_n = rst_s2_ff;

  // Pin synchronisers; the third stage only feeds the edge detector
  reg [1:0] ck_sync_ff;
  reg ck_prev_ff;
  reg [1:0] gate_sync_ff;

  // Clock pin reads low after reset; an early rise is harmless while unarmed
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ck_sync_ff <= 2'h0;
      ck_prev_ff <= 1'b0;
    end else begin
      ck_sync_ff <= {ck_sync_ff[0], ext_count_clock};
      ck_prev_ff <= ck_sync_ff[1];
    end
  end

  // Gate resets closed so counting never starts on a stale low
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_sync_ff <= 2'h3;
    end else begin
      gate_sync_ff <= {gate_sync_ff[0], count_gate_n};
    end
  end

  // Edges are taken from the synchronised copy only
  wire ext_rise;
  wire ext_fall;
  wire gate_n_s;

  assign ext_rise = ck_sync_ff[1] & ~ck_prev_ff;
  assign ext_fall = ~ck_sync_ff[1] & ck_prev_ff;
  assign gate_n_s = gate_sync_ff[1];

  // Registers
  reg [6:0] tctl_ff;
  reg [1:0] intctl_ff;
  reg ovf_ff;
  reg ovf_ie_ff;
  reg [15:0] count_ff;
  reg [2:0] presc_ff;
  reg armed_ff;
  reg [7:0] idiv_ff;

  wire counter_on;
  wire clock_source_select;
  wire sync_control_n;
  wire crystal_osc_enable;
  wire [1:0] prescale_select;
  wire gate_enable;
  wire peripheral_irq_enable;
  wire global_irq_enable;

  assign counter_on = tctl_ff[`GTC_BIT_ON];
  assign clock_source_select = tctl_ff[`GTC_BIT_SRC];
  assign sync_control_n = tctl_ff[`GTC_BIT_SYNC_N];
  assign crystal_osc_enable = tctl_ff[`GTC_BIT_OSC];
  assign prescale_select = tctl_ff[`GTC_BIT_PS_HI:`GTC_BIT_PS_LO];
  assign gate_enable = tctl_ff[`GTC_BIT_GATE];
  assign peripheral_irq_enable = intctl_ff[0];
  assign global_irq_enable = intctl_ff[1];

  // Write decode
  reg wr_intctl;
  reg wr_pflags;
  reg wr_lo;
  reg wr_hi;
  reg wr_tctl;
  reg wr_pen;

  // One strobe at most; unmapped addresses fall through untouched
  always @* begin
    wr_intctl = 1'b0;
    wr_pflags = 1'b0;
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    wr_tctl = 1'b0;
    wr_pen = 1'b0;
    if (reg_wr) begin
      if (reg_addr == `GTC_ADDR_INTCTL) begin
        wr_intctl = 1'b1;
      end else if (reg_addr == `GTC_ADDR_PFLAGS) begin
        wr_pflags = 1'b1;
      end else if (reg_addr == `GTC_ADDR_CNTLO) begin
        wr_lo = 1'b1;
      end else if (reg_addr == `GTC_ADDR_CNTHI) begin
        wr_hi = 1'b1;
      end else if (reg_addr == `GTC_ADDR_TCTL) begin
        wr_tctl = 1'b1;
      end else if (reg_addr == `GTC_ADDR_PENABLE) begin
        wr_pen = 1'b1;
      end
    end
  end

  // Instruction-cycle enable from the system clock
  // Free-running, so a timer start lands anywhere in an instruction cycle
  wire instr_tick;

  assign instr_tick = (idiv_ff == INSTR_DIV[7:0] - 8'h01);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idiv_ff <= 8'h00;
    end else if (instr_tick) begin
      idiv_ff <= 8'h00;
    end else begin
      idiv_ff <= idiv_ff + 8'h01;
    end
  end

  // Source selection and gating
  reg src_tick;
  reg allowed;
  wire gate_open;

  always @* begin
    if (clock_source_select) begin
      src_tick = ext_rise & armed_ff;
    end else begin
      src_tick = instr_tick;
    end
  end

  // Synchronised counting halts in sleep; only the unsynchronised path runs
  always @* begin
    if (!sleep_mode) begin
      allowed = 1'b1;
    end else if (clock_source_select && sync_control_n) begin
      allowed = 1'b1;
    end else begin
      allowed = 1'b0;
    end
  end

  assign gate_open = !gate_enable || !gate_n_s;

  wire clk_tick;

  assign clk_tick = counter_on && allowed && gate_open && src_tick;

  // Prescaler: 1, 2, 4 or 8
  localparam [1:0] PS_DIV1 = 2'b00;
  localparam [1:0] PS_DIV2 = 2'b01;
  localparam [1:0] PS_DIV4 = 2'b10;
  localparam [1:0] PS_DIV8 = 2'b11;
  reg presc_done;

  always @* begin
    case (prescale_select)
      PS_DIV1: presc_done = 1'b1;
      PS_DIV2: presc_done = (presc_ff[0] == 1'b1);
      PS_DIV4: presc_done = (presc_ff[1:0] == 2'h3);
      PS_DIV8: presc_done = (presc_ff == 3'h7);
      default: presc_done = 1'b1;
    endcase
  end

  wire inc;
  wire wrap;
  wire ovf_set;

  assign inc = clk_tick && presc_done;
  assign wrap = inc && (count_ff == 16'hffff);
  assign ovf_set = wrap;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_ff <= 3'h0;
    end else if (wr_lo || wr_hi) begin
      // A new start value begins a full prescale period
      presc_ff <= 3'h0;
    end else if (clk_tick) begin
      if (presc_done) begin
        presc_ff <= 3'h0;
      end else begin
        presc_ff <= presc_ff + 3'h1;
      end
    end
  end

  // Falling edge must be seen after enabling
  // Cleared while off, so every enable waits for a fresh falling edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_ff <= 1'b0;
    end else if (!counter_on || !clock_source_select) begin
      armed_ff <= 1'b0;
    end else if (ext_fall) begin
      armed_ff <= 1'b1;
    end
  end

  // Count; a byte write wins over an increment in the same cycle
  // The tick that meets a write is lost, which is why software stops first
  genvar gi;
  wire [15:0] count_inc;
  wire [1:0] byte_wr;

  assign count_inc = count_ff + 16'h0001;
  assign byte_wr = {wr_hi, wr_lo};

  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_byte
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          count_ff[gi*8 +: 8] <= 8'h00;
        end else if (byte_wr[gi]) begin
          count_ff[gi*8 +: 8] <= reg_wdata;
        end else if (inc && (byte_wr == 2'h0)) begin
          count_ff[gi*8 +: 8] <= count_inc[gi*8 +: 8];
        end
      end
    end
  endgenerate

  // Control registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tctl_ff <= `GTC_TCTL_RESET;
    end else if (wr_tctl) begin
      tctl_ff <= reg_wdata[6:0];
    end
  end

  // Only the two enables are stored; the other bits belong elsewhere
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intctl_ff <= `GTC_INTCTL_RESET;
    end else if (wr_intctl) begin
      intctl_ff <= {reg_wdata[`GTC_BIT_GIE], reg_wdata[`GTC_BIT_PERIPHERAL_IRQ_ENABLE]};
    end
  end

  // Overflow enable
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_ie_ff <= 1'b0;
    end else if (wr_pen) begin
      ovf_ie_ff <= reg_wdata[`GTC_BIT_OVF];
    end
  end

  // Overflow flag: a rollover beats a software clear in the same cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_ff <= 1'b0;
    end else if (ovf_set) begin
      ovf_ff <= 1'b1;
    end else if (wr_pflags) begin
      ovf_ff <= reg_wdata[`GTC_BIT_OVF];
    end
  end

  // Interrupt and wake share the flag and the two lower enables
  wire ovf_armed;

  assign ovf_armed = ovf_ff && ovf_ie_ff && peripheral_irq_enable;
  assign irq_out = ovf_armed && global_irq_enable;
  // Wake ignores the global enable; that only picks vector or fall-through
  assign wake_out = sleep_mode && ovf_armed && counter_on;

  // Oscillator enable
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_power_crystal_osc <= 1'b0;
    end else begin
      low_power_crystal_osc <= crystal_osc_enable;
    end
  end

  // Pins 4 and 5 are handled alike, one copy per bit
  // The oscillator owns both pins while it runs
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
      reg lvl_s1_ff;
      reg lvl_s2_ff;

      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          lvl_s1_ff <= 1'b0;
          lvl_s2_ff <= 1'b0;
          pin45_dir_out[gi] <= 1'b1;
          pin45_read_out[gi] <= 1'b0;
        end else begin
          lvl_s1_ff <= pin45_level_in[gi];
          lvl_s2_ff <= lvl_s1_ff;
          if (crystal_osc_enable) begin
            pin45_dir_out[gi] <= 1'b1;
            pin45_read_out[gi] <= 1'b0;
          end else begin
            pin45_dir_out[gi] <= pin45_dir_in[gi];
            pin45_read_out[gi] <= lvl_s2_ff;
          end
        end
      end
    end
  endgenerate

  // Read port; the count is held in flip-flops on this clock, so a byte
  // read never sees a half-updated value
  reg [7:0] rd_mux;

  always @* begin
    rd_mux = 8'h00;
    if (reg_addr == `GTC_ADDR_INTCTL) begin
      rd_mux = {intctl_ff, 6'h00};
    end else if (reg_addr == `GTC_ADDR_PFLAGS) begin
      rd_mux = {7'h00, ovf_ff};
    end else if (reg_addr == `GTC_ADDR_CNTLO) begin
      rd_mux = count_ff[7:0];
    end else if (reg_addr == `GTC_ADDR_CNTHI) begin
      rd_mux = count_ff[15:8];
    end else if (reg_addr == `GTC_ADDR_TCTL) begin
      rd_mux = {1'b0, tctl_ff};
    end else if (reg_addr == `GTC_ADDR_PENABLE) begin
      rd_mux = {7'h00, ovf_ie_ff};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // gtc_timer

/* dv/gtc_timer_chk.sv */
// Port-level assertions for the timer/counter
`timescale 1ns/1ps
module gtc_timer_chk (
  input wire clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire sleep_mode,
  input wire [1:0] pin45_dir_in,
  input wire [1:0] pin45_dir_out,
  input wire [1:0] pin45_read_out,
  input wire low_power_crystal_osc,
  input wire irq_out,
  input wire wake_out
);
  reg [1:0] rst_cnt_ff;
  reg gie_ff, peripheral_irq_enable_ff, ovfe_ff, on_ff;
  reg [6:0] tctl_sh;
  // Internal reset trails reset_n by two flops
  wire rdy = rst_cnt_ff == 2'h3;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_cnt_ff <= 2'h0;
      {gie_ff, peripheral_irq_enable_ff, ovfe_ff, on_ff} <= 4'h0;
      tctl_sh <= 7'h00;
    end else begin
      if (!rdy) rst_cnt_ff <= rst_cnt_ff + 2'h1;
      if (reg_wr && reg_addr == 8'h0b) {gie_ff, peripheral_irq_enable_ff} <= reg_wdata[7:6];
      if (reg_wr && reg_addr == 8'h8c) ovfe_ff <= reg_wdata[0];
      if (reg_wr && reg_addr == 8'h10) on_ff <= reg_wdata[0];
      if (reg_wr && reg_addr == 8'h10) tctl_sh <= reg_wdata[6:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_ctl_readback: assert property (rdy && $past(reg_rd) && $past(reg_addr) == 8'h10
    |-> reg_rdata == {1'b0, $past(tctl_sh)})
    else $error("control readback wrong");
  a_osc_follows: assert property (rdy && reg_wr && reg_addr == 8'h10 ##1
    !(reg_wr && reg_addr == 8'h10) |=> low_power_crystal_osc == $past(reg_wdata[3], 2))
    else $error("oscillator enable wrong");
  a_osc_pins: assert property (low_power_crystal_osc && $past(low_power_crystal_osc)
    |-> pin45_dir_out == 2'h3 && pin45_read_out == 2'h0)
    else $error("pins not forced");
  a_dir_pass: assert property (rdy && $past(rdy) && !low_power_crystal_osc
    && !$past(low_power_crystal_osc) |-> pin45_dir_out == $past(pin45_dir_in))
    else $error("direction not passed");
  a_irq_mask: assert property (irq_out |-> gie_ff && peripheral_irq_enable_ff && ovfe_ff)
    else $error("irq without enables");
  a_wake_mask: assert property (wake_out |-> sleep_mode && peripheral_irq_enable_ff && ovfe_ff && on_ff)
    else $error("wake without enables");
  a_irq_sticky: assert property (irq_out && !reg_wr |=> irq_out)
    else $error("irq dropped alone");
endmodule // gtc_timer_chk
bind gtc_timer gtc_timer_chk gtc_timer_chk_i (.*);

/* dv/gtc_clk_src.sv */
// Model of the external count clock source
`timescale 1ns/1ps
module gtc_clk_src (
  output reg ext_count_clock
);
  integer k;
  initial ext_count_clock = 1'b1;
  // Stands still between bursts, like a gated source
  task park(input lvl);
    ext_count_clock = lvl;
  endtask
  task burst(input integer n, input integer half);
    for (k = 0; k < 2 * n; k = k + 1)
      #(half) ext_count_clock = ~ext_count_clock;
  endtask
endmodule // gtc_clk_src

/* dv/gtc_timer_bench.sv */
// Self-checking bench for the timer/counter
`timescale 1ns/1ps
module gtc_timer_bench;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg count_gate_n = 1'b0;
  reg sleep_mode = 1'b0;
  reg [1:0] pin45_dir_in = 2'h0;
  reg [1:0] pin45_level_in = 2'h3;
  wire [7:0] reg_rdata;
  wire ext_count_clock;
  wire [1:0] pin45_dir_out;
  wire [1:0] pin45_read_out;
  wire low_power_crystal_osc, irq_out, wake_out;
  integer err_total = 0;
  integer n_checks = 0;
  integer ps;
  reg [7:0] v;
  always #2 clk = ~clk;
  gtc_timer #(.INSTR_DIV(4)) gtc_timer_i (
    .clk(clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .ext_count_clock(ext_count_clock),
    .count_gate_n(count_gate_n),
    .sleep_mode(sleep_mode),
    .pin45_dir_in(pin45_dir_in),
    .pin45_level_in(pin45_level_in),
    .pin45_dir_out(pin45_dir_out),
    .pin45_read_out(pin45_read_out),
    .low_power_crystal_osc(low_power_crystal_osc),
    .irq_out(irq_out),
    .wake_out(wake_out)
  );
  gtc_clk_src gtc_clk_src_i (.ext_count_clock(ext_count_clock));
  task chk(input [15:0] nm, input [7:0] e, input [7:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    // One idle edge so a following call never re-raises the strobe at once
    @(posedge clk);
  endtask
  task rd(input [7:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clk);
  endtask
  task rdc(input [7:0] a, input [7:0] e, input [15:0] nm);
    rd(a);
    chk(nm, e, v);
  endtask
  // Counter stopped and cleared before each run, so the prescaler starts empty
  task ext(input [7:0] c, input lvl, input integer n, input [7:0] e);
    wr(8'h10, 8'h00);
    gtc_clk_src_i.park(lvl);
    wr(8'h0e, 8'h00);
    wr(8'h0f, 8'h00);
    wr(8'h10, c);
    gtc_clk_src_i.burst(n, 42);
    repeat (4) @(posedge clk);
    rdc(8'h0e, e, "lo");
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    err_total = err_total + 1;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(8'h10, 8'h00, "tc");
    rdc(8'h0b, 8'h00, "ic");
    wr(8'h10, 8'hff);
    rdc(8'h10, 8'h7f, "tc");
    rdc(8'h55, 8'h00, "un");
    wr(8'h10, 8'h00);
    wr(8'h0e, 8'h00);
    wr(8'h0f, 8'h00);
    wr(8'h10, 8'h01);
    repeat (255) @(posedge clk);
    wr(8'h10, 8'h00);
    rd(8'h0e);
    chk("tm", 8'h01, {7'h00, v > 8'h3e && v < 8'h42});
    wr(8'h0e, 8'hff);
    wr(8'h0f, 8'hff);
    wr(8'h0c, 8'h00);
    wr(8'h8c, 8'h01);
    wr(8'h0b, 8'hc0);
    wr(8'h10, 8'h01);
    repeat (12) @(posedge clk);
    #1 chk("iq", 8'h01, {7'h00, irq_out});
    @(posedge clk);
    rdc(8'h0c, 8'h01, "fl");
    rdc(8'h0f, 8'h00, "oh");
    wr(8'h0b, 8'h40);
    #1 chk("iq", 8'h00, {7'h00, irq_out});
    @(posedge clk);
    rdc(8'h0c, 8'h01, "fl");
    wr(8'h0c, 8'h00);
    rdc(8'h0c, 8'h00, "fc");
    ext(8'h03, 1'b1, 5, 8'h05);
    ext(8'h03, 1'b0, 5, 8'h04);
    count_gate_n <= 1'b1;
    ext(8'h43, 1'b1, 4, 8'h00);
    count_gate_n <= 1'b0;
    ext(8'h43, 1'b1, 4, 8'h04);
    for (ps = 0; ps < 4; ps = ps + 1)
      ext({2'h0, ps[1:0], 4'h3}, 1'b1, 8, 8'h08 >> ps);
    sleep_mode <= 1'b1;
    ext(8'h07, 1'b1, 3, 8'h03);
    ext(8'h03, 1'b1, 3, 8'h00);
    wr(8'h10, 8'h00);
    wr(8'h0e, 8'hff);
    wr(8'h0f, 8'hff);
    wr(8'h10, 8'h07);
    gtc_clk_src_i.burst(2, 402);
    repeat (4) @(posedge clk);
    #1 chk("wk", 8'h01, {7'h00, wake_out});
    chk("iq", 8'h00, {7'h00, irq_out});
    @(posedge clk);
    wr(8'h0b, 8'hc0);
    #1 chk("iq", 8'h01, {7'h00, irq_out});
    @(posedge clk);
    sleep_mode <= 1'b0;
    wr(8'h10, 8'h08);
    repeat (2) @(posedge clk);
    #1 chk("os", 8'h01, {7'h00, low_power_crystal_osc});
    chk("dr", 8'h03, {6'h00, pin45_dir_out});
    chk("pr", 8'h00, {6'h00, pin45_read_out});
    @(posedge clk);
    wr(8'h10, 8'h00);
    repeat (4) @(posedge clk);
    #1 chk("dr", 8'h00, {6'h00, pin45_dir_out});
    chk("pr", 8'h03, {6'h00, pin45_read_out});
    report_and_stop;
  end
endmodule // gtc_timer_bench
